// >>> logic/clk_ctrl_pkg.sv
// Constants and types for the clock chip control block
package clk_ctrl_pkg;
    // ****************
    // Serial slave
    // ****************
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam int N_REG = 7;
    localparam logic [7:0] N_REG_BYTE = 8'h07;
    localparam logic [7:0] CFG0_RST = 8'h00;
    localparam logic [7:0] CFG1_RST = 8'h7D;
    localparam logic [7:0] CFG2_RST = 8'h7F;
    localparam logic [7:0] CFG3_RST = 8'h67;
    localparam logic [7:0] CFG4_RST = 8'hCF;
    localparam logic [7:0] CFG5_RST = 8'h7F;
    localparam logic [7:0] CFG6_RST = 8'h00;
    localparam int OVR_BIT = 3;
    localparam int PINFN_BIT = 7;
    // ****************
    // Clock outputs
    // ****************
    localparam int N_CLK = 23;
    localparam int CK_CPU = 0;
    localparam int CK_CRYSTAL_COPY_OUT_B = 14;
    // ****************
    // Timing
    // ****************
    localparam int CLK_MHZ = 20;
    localparam int SETTLE_NS = 500000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W = 16;
    // ****************
    // Preset table, tenths of MHz
    // ****************
    localparam logic [15:0][11:0] CPU_TAB = {
        12'h682, 12'h7D0, 12'h535, 12'h3E8, 12'h682, 12'h685, 12'h7D0,
        12'h7D9, 12'h7C0, 12'h708, 12'h5AC, 12'h44C, 12'h535, 12'h53B,
        12'h3E8, 12'h3F1};
    localparam logic [15:0][11:0] AGP_TAB = {
        12'h29A, 12'h29B, 12'h29B, 12'h29B, 12'h29A, 12'h29C, 12'h29B,
        12'h29D, 12'h2CD, 12'h2D0, 12'h2D6, 12'h2DD, 12'h29B, 12'h29D,
        12'h29B, 12'h2A1};
    localparam logic [15:0][11:0] PCI_TAB = {
        12'h14D, 12'h14D, 12'h14D, 12'h14D, 12'h14D, 12'h14E, 12'h14D,
        12'h14F, 12'h166, 12'h168, 12'h16B, 12'h16F, 12'h14D, 12'h14F,
        12'h14D, 12'h150};
    // ****************
    // Serial slave states
    // ****************
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_ADDR = 4'h1, S_ADDR_ACK = 4'h2, S_CMD = 4'h3,
        S_CMD_ACK = 4'h4, S_CNT = 4'h5, S_CNT_ACK = 4'h6, S_WR = 4'h7,
        S_WR_ACK = 4'h8, S_TX = 4'h9, S_MACK = 4'hA
    } ser_state_type;
endpackage

// >>> logic/clock_chip_strap_and_serial_ctrl.sv
// Strap latching, clock gating and serial slave of the clock chip
`timescale 1ns/1ns
module clock_chip_strap_and_serial_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int P_SETTLE_CYCLES = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Strap pins and supply threshold
    input wire logic i_supply_ok,
    input wire logic [3:0] i_freq_select_strap,
    input wire logic i_cpu_family_strap,
    input wire logic i_current_multiplier_strap,
    output logic o_strap_pins_oe,
    // Power-good and shared power-down pin
    input wire logic i_power_good_qualifier_n,
    input wire logic i_power_down_in_n,
    input wire logic i_system_reset_req,
    output logic o_system_reset_out_n,
    output logic o_system_reset_out_n_oe,
    output logic o_power_down,
    // Clock sources and gated outputs
    input wire logic [N_CLK-1:0] i_src_clk,
    output logic [N_CLK-1:0] o_clk_out,
    output logic o_cpu_clock_true,
    output logic o_cpu_clock_true_oe,
    output logic o_cpu_clock_comp,
    output logic o_cpu_clock_comp_oe,
    // Status
    output logic [3:0] o_freq_code,
    output logic [11:0] o_cpu_tenths_mhz,
    output logic [11:0] o_agp_tenths_mhz,
    output logic [11:0] o_pci_tenths_mhz,
    output logic o_cpu_push_pull,
    output logic o_current_mult_six,
    output logic o_synth_settled,
    // Serial link
    input wire logic i_serial_clock,
    input wire logic i_serial_data_pin,
    output logic o_serial_data_pin,
    output logic o_serial_data_pin_oe
);
    // ****************
    // Input synchronisers
    // ****************
    logic [8:0] pin_m_reg;
    logic [8:0] pin_s_reg;
    logic [N_CLK-1:0] src_m_reg;
    logic [N_CLK-1:0] src_s_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic pg_d_reg;
    wire [8:0] pin_raw = {i_serial_data_pin, i_serial_clock,
        i_power_down_in_n, i_power_good_qualifier_n, i_supply_ok,
        i_current_multiplier_strap, i_cpu_family_strap,
        i_freq_select_strap[3:2]};
    logic [1:0] fs_lo_m_reg;
    logic [1:0] fs_lo_s_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_m_reg <= 9'h1E0;
            pin_s_reg <= 9'h1E0;
            fs_lo_m_reg <= 2'h0;
            fs_lo_s_reg <= 2'h0;
            src_m_reg <= '0;
            src_s_reg <= '0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            pg_d_reg <= 1'b1;
        end else begin
            pin_m_reg <= pin_raw;
            pin_s_reg <= pin_m_reg;
            fs_lo_m_reg <= i_freq_select_strap[1:0];
            fs_lo_s_reg <= fs_lo_m_reg;
            src_m_reg <= i_src_clk;
            src_s_reg <= src_m_reg;
            scl_d_reg <= pin_s_reg[7];
            sda_d_reg <= pin_s_reg[8];
            pg_d_reg <= pin_s_reg[5];
        end
    end

    wire [3:0] fs_s = {pin_s_reg[1:0], fs_lo_s_reg};
    wire fam_s = pin_s_reg[2];
    wire mult_s = pin_s_reg[3];
    wire sup_s = pin_s_reg[4];
    wire pg_s = pin_s_reg[5];
    wire pd_s = pin_s_reg[6];
    wire scl_s = pin_s_reg[7];
    wire sda_s = pin_s_reg[8];

    // ****************
    // Strap latch and power-good
    // ****************
    logic latched_reg;
    logic pg_done_reg;
    logic [3:0] fs_reg;
    logic pp_mode_reg;
    logic mult_reg;
    logic [SETTLE_W-1:0] settle_reg;
    logic settled_reg;
    logic [7:0] cfg_reg [0:N_REG-1];
    wire pg_fall = pp_mode_reg & latched_reg & ~pg_done_reg
        & pg_d_reg & ~pg_s;
    wire first_latch = sup_s & ~latched_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latched_reg <= 1'b0;
            pg_done_reg <= 1'b0;
            fs_reg <= 4'h0;
            pp_mode_reg <= 1'b0;
            mult_reg <= 1'b0;
        end else begin
            if (first_latch) begin
                latched_reg <= 1'b1;
                pp_mode_reg <= fam_s;
            end
            if (first_latch || pg_fall) begin
                fs_reg <= fs_s;
                mult_reg <= mult_s;
            end
            if (pg_fall) begin
                pg_done_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            settle_reg <= '0;
            settled_reg <= 1'b0;
        end else if (latched_reg && !settled_reg) begin
            settle_reg <= settle_reg + 1'b1;
            settled_reg <= (settle_reg ==
                SETTLE_W'(P_SETTLE_CYCLES - 1));
        end
    end

    wire [3:0] fs_eff = cfg_reg[0][OVR_BIT] ?
        {cfg_reg[0][1], cfg_reg[0][6:4]} : fs_reg;
    wire pin_is_pd = cfg_reg[6][PINFN_BIT];
    wire power_down = pin_is_pd & ~pd_s;
    wire clocks_ok = latched_reg & settled_reg & ~power_down
        & (~pp_mode_reg | pg_done_reg);
    wire [N_CLK-1:0] en_vec = {cfg_reg[5][6:0], cfg_reg[4][3],
        cfg_reg[4][2] & ~pp_mode_reg, cfg_reg[3][6:5], cfg_reg[3][2:0],
        cfg_reg[2][6:0], cfg_reg[1][3:2]};

    // ****************
    // Glitch-free clock gates except comp_reg
    // ****************
    logic [N_CLK-1:0] run_reg;
    logic [N_CLK-1:0] out_reg;
    logic comp_reg;
    genvar g;
    generate
        for (g = 0; g < N_CLK; g = g + 1) begin : gate_gen
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    run_reg[g] <= 1'b0;
                    out_reg[g] <= 1'b0;
                end else begin
                    if (!src_s_reg[g]) begin
                        run_reg[g] <= clocks_ok & en_vec[g];
                    end
                    out_reg[g] <= src_s_reg[g] & run_reg[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            comp_reg <= 1'b0;
        end else begin
            comp_reg <= ~src_s_reg[CK_CPU] & run_reg[CK_CPU];
        end
    end

    // ****************
    // Serial slave
    // ****************
    ser_state_type st_reg;
    logic [2:0] bit_reg;
    logic full_reg;
    logic [7:0] sh_reg;
    logic [6:0] idx_reg;
    logic [7:0] cnt_reg;
    logic block_reg;
    logic cmd_ok_reg;
    logic rd_reg;
    logic tx_cnt_reg;
    logic mack_reg;
    logic drv_reg;

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire in_rx = (st_reg == S_ADDR) | (st_reg == S_CMD)
        | (st_reg == S_CNT) | (st_reg == S_WR);
    wire addr_wr = (sh_reg == {SLAVE_ADDR, 1'b0});
    wire addr_rd = (sh_reg == {SLAVE_ADDR, 1'b1}) & cmd_ok_reg;
    // byte op, or block with zero index
    wire cmd_good = sh_reg[7] | (sh_reg[6:0] == 7'h00);
    // writes beyond the map are dropped
    wire idx_in = (idx_reg < 7'(N_REG));
    wire wr_fire = scl_fall & full_reg & (st_reg == S_WR)
        & (cnt_reg != 8'h00) & idx_in;
    wire [6:0] nxt_idx = tx_cnt_reg ? idx_reg : idx_reg + 7'h01;

    function automatic logic [7:0] rd_byte(input logic [6:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            7'h00: v = {1'b0, fs_eff[2:0], cfg_reg[0][OVR_BIT], 1'b0,
                fs_eff[3], pp_mode_reg};
            7'h01: v = {cfg_reg[1][7:1], mult_reg};
            7'h02: v = cfg_reg[2];
            7'h03: v = cfg_reg[3];
            7'h04: v = cfg_reg[4];
            7'h05: v = cfg_reg[5];
            7'h06: v = cfg_reg[6];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Select bits track straps until override
    wire ovr = cfg_reg[0][OVR_BIT];
    wire [7:0] wr_val = (idx_reg == 7'h00) ? {1'b0,
        ovr ? sh_reg[6:4] : fs_reg[2:0], sh_reg[3], 1'b0,
        ovr ? sh_reg[1] : fs_reg[3], 1'b0} : sh_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_reg[0] <= CFG0_RST;
            cfg_reg[1] <= CFG1_RST;
            cfg_reg[2] <= CFG2_RST;
            cfg_reg[3] <= CFG3_RST;
            cfg_reg[4] <= CFG4_RST;
            cfg_reg[5] <= CFG5_RST;
            cfg_reg[6] <= CFG6_RST;
        end else if (wr_fire) begin
            cfg_reg[idx_reg[2:0]] <= wr_val;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= S_IDLE;
            bit_reg <= 3'h0;
            full_reg <= 1'b0;
            sh_reg <= 8'h00;
            idx_reg <= 7'h00;
            cnt_reg <= 8'h00;
            block_reg <= 1'b0;
            cmd_ok_reg <= 1'b0;
            rd_reg <= 1'b0;
            tx_cnt_reg <= 1'b0;
            mack_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (stop_det) begin
            st_reg <= S_IDLE;
            cmd_ok_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (start_det) begin
            st_reg <= S_ADDR;
            bit_reg <= 3'h0;
            full_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (scl_rise && in_rx) begin
            sh_reg <= {sh_reg[6:0], sda_s};
            bit_reg <= bit_reg + 3'h1;
            full_reg <= (bit_reg == 3'h7);
        end else if (scl_rise && st_reg == S_MACK) begin
            mack_reg <= ~sda_s;
        end else if (scl_fall) begin
            full_reg <= 1'b0;
            case (st_reg)
                S_ADDR: if (full_reg) begin
                    rd_reg <= addr_rd;
                    drv_reg <= addr_wr | addr_rd;
                    st_reg <= (addr_wr | addr_rd) ? S_ADDR_ACK : S_IDLE;
                end
                S_CMD: if (full_reg) begin
                    block_reg <= ~sh_reg[7];
                    idx_reg <= sh_reg[6:0];
                    cnt_reg <= 8'h01;
                    cmd_ok_reg <= cmd_good;
                    drv_reg <= cmd_good;
                    st_reg <= cmd_good ? S_CMD_ACK : S_IDLE;
                end
                S_CNT: if (full_reg) begin
                    cnt_reg <= sh_reg;
                    drv_reg <= 1'b1;
                    st_reg <= S_CNT_ACK;
                end
                S_WR: if (full_reg) begin
                    if (cnt_reg != 8'h00) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                    if (block_reg) begin
                        idx_reg <= idx_reg + 7'h01;
                    end
                    drv_reg <= 1'b1;
                    st_reg <= S_WR_ACK;
                end
                S_ADDR_ACK: begin
                    bit_reg <= 3'h0;
                    if (rd_reg) begin
                        tx_cnt_reg <= block_reg;
                        sh_reg <= block_reg ? N_REG_BYTE :
                            rd_byte(idx_reg);
                        drv_reg <= block_reg ? ~N_REG_BYTE[7] :
                            (rd_byte(idx_reg) < 8'h80);
                        st_reg <= S_TX;
                    end else begin
                        drv_reg <= 1'b0;
                        st_reg <= S_CMD;
                    end
                end
                S_CMD_ACK: begin
                    drv_reg <= 1'b0;
                    st_reg <= block_reg ? S_CNT : S_WR;
                end
                S_CNT_ACK, S_WR_ACK: begin
                    // further bytes take the write path
                    drv_reg <= 1'b0;
                    st_reg <= S_WR;
                end
                S_TX: begin
                    // pull low for zero bits only
                    if (bit_reg == 3'h7) begin
                        drv_reg <= 1'b0;
                        st_reg <= S_MACK;
                    end else begin
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        drv_reg <= ~sh_reg[6];
                    end
                    bit_reg <= bit_reg + 3'h1;
                end
                S_MACK: begin
                    if (mack_reg) begin
                        tx_cnt_reg <= 1'b0;
                        idx_reg <= nxt_idx;
                        sh_reg <= rd_byte(nxt_idx);
                        drv_reg <= (rd_byte(nxt_idx) < 8'h80);
                        st_reg <= S_TX;
                    end else begin
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // ****************
    // Outputs
    // ****************
    assign o_strap_pins_oe = latched_reg;
    assign o_clk_out = out_reg;
    assign o_cpu_clock_true = pp_mode_reg & out_reg[CK_CPU];
    assign o_cpu_clock_true_oe = pp_mode_reg | ~out_reg[CK_CPU];
    assign o_cpu_clock_comp = pp_mode_reg & comp_reg;
    assign o_cpu_clock_comp_oe = pp_mode_reg | ~comp_reg;
    // open-drain reset output when not power-down
    assign o_system_reset_out_n = 1'b0;
    assign o_system_reset_out_n_oe = ~pin_is_pd & i_system_reset_req;
    assign o_power_down = power_down;
    assign o_freq_code = fs_eff;
    assign o_cpu_tenths_mhz = CPU_TAB[fs_eff];
    assign o_agp_tenths_mhz = AGP_TAB[fs_eff];
    assign o_pci_tenths_mhz = PCI_TAB[fs_eff];
    assign o_cpu_push_pull = pp_mode_reg;
    assign o_current_mult_six = mult_reg;
    assign o_synth_settled = settled_reg;
    assign o_serial_data_pin = 1'b0;
    assign o_serial_data_pin_oe = drv_reg;
endmodule

// >>> dv/ctrl_chk.sv
// Port assertions for the clock chip control block
`timescale 1ns/1ns
module ctrl_chk
    import clk_ctrl_pkg::*;
#(
    parameter int P_SETTLE_CYCLES = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Pins
    input wire logic i_power_down_in_n,
    input wire logic i_system_reset_req,
    input wire logic o_system_reset_out_n,
    input wire logic o_system_reset_out_n_oe,
    input wire logic o_power_down,
    input wire logic o_serial_data_pin,
    // Clocks and status
    input wire logic [N_CLK-1:0] o_clk_out,
    input wire logic o_cpu_clock_true,
    input wire logic o_cpu_clock_true_oe,
    input wire logic o_cpu_clock_comp,
    input wire logic o_cpu_clock_comp_oe,
    input wire logic o_strap_pins_oe,
    input wire logic o_synth_settled,
    input wire logic o_cpu_push_pull,
    input wire logic [3:0] o_freq_code,
    input wire logic [11:0] o_cpu_tenths_mhz
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [15:0] wait_reg;
    logic [15:0] wait_next;
    // ****************
    // Settle counter
    // ****************
    assign wait_next = !o_strap_pins_oe ? 16'h0 :
        (o_synth_settled ? wait_reg : wait_reg + 16'h1);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_reg <= 16'h0;
        end else begin
            wait_reg <= wait_next;
        end
    end
    // ****************
    // Assertions
    // ****************
    chk_sda_open_drain: assert property (
        o_serial_data_pin == 1'b0)
        else $error("Serial data pin driven high");
    chk_reset_pin_low: assert property (
        o_system_reset_out_n_oe |-> i_system_reset_req && !o_power_down
        && o_system_reset_out_n == 1'b0)
        else $error("Reset pin driven without request");
    chk_pd_from_pin: assert property (
        o_power_down |-> !$past(i_power_down_in_n, 2)
        || !$past(i_power_down_in_n, 3))
        else $error("Power-down without low pin");
    chk_pd_gates_low: assert property (
        o_power_down [*8] |-> o_clk_out == '0)
        else $error("Clock runs in power-down");
    chk_held_unsettled: assert property (
        !o_synth_settled || !o_strap_pins_oe |-> o_clk_out == '0)
        else $error("Clock before settle");
    chk_settle_count: assert property (
        $rose(o_synth_settled) |-> wait_reg >= P_SETTLE_CYCLES - 1
        && wait_reg <= P_SETTLE_CYCLES + 1)
        else $error("Settle time wrong");
    chk_push_pull_oe: assert property (
        o_cpu_push_pull |-> o_cpu_clock_true_oe && o_cpu_clock_comp_oe)
        else $error("Push-pull pair not driven");
    chk_open_drain_val: assert property (
        o_strap_pins_oe && !o_cpu_push_pull
        |-> !o_cpu_clock_true && !o_cpu_clock_comp)
        else $error("Open-drain pair driven high");
    chk_table_entry: assert property (
        o_freq_code == 4'hA |-> o_cpu_tenths_mhz == 12'h685)
        else $error("Frequency table entry wrong");
    chk_family_kept: assert property (
        o_strap_pins_oe && $past(o_strap_pins_oe)
        |-> $stable(o_cpu_push_pull))
        else $error("Family mode changed after latch");
    for (genvar k = 0; k < N_CLK; k++) begin : g_high
        chk_full_high: assert property (
            $rose(o_clk_out[k]) |=> o_clk_out[k])
            else $error("Clock high phase cut short");
    end
endmodule

// >>> dv/smb_host.sv
// Two-wire host model for the serial link
`timescale 1ns/1ns
module smb_host (
    // Clock
    input wire logic i_clk,
    // Bus lines
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // ****************
    // Bit and byte level
    // ****************
    task automatic q();
        repeat (2) @(negedge i_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        q();
        o_sda_oe = !b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
    endtask
    task automatic start();
        q();
        o_sda_oe = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b0;
        q();
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // ****************
    // Transactions
    // ****************
    // Writes, then stop
    task automatic bwrite(input logic [7:0] adr, input logic [7:0] cmd,
        input logic [7:0] d[$], output int acks);
        logic a;
        start();
        put(adr, a);
        acks = a;
        put(cmd, a);
        acks += a;
        foreach (d[i]) begin
            put(d[i], a);
            acks += a;
        end
        stop();
    endtask
    task automatic bread(input logic [7:0] cmd, input int n,
        output logic [7:0] d[$], output int acks);
        logic a;
        logic [7:0] v;
        d = {};
        start();
        put(8'hD2, a);
        acks = a;
        put(cmd, a);
        acks += a;
        start();
        put(8'hD3, a);
        acks += a;
        for (int i = 0; i < n; i++) begin
            get(i == n - 1, v);
            d.push_back(v);
        end
        stop();
    endtask
endmodule

// >>> dv/clock_chip_strap_and_serial_ctrl_tb.sv
// Testbench for the clock chip control block
`timescale 1ns/1ns
bind clock_chip_strap_and_serial_ctrl ctrl_chk
    #(.P_SETTLE_CYCLES(P_SETTLE_CYCLES)) ctrl_chk_inst (.*);
module clock_chip_strap_and_serial_ctrl_tb;
    import clk_ctrl_pkg::*;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_supply_ok = 1'b0;
    logic [3:0] i_freq_select_strap = 4'hA;
    logic i_cpu_family_strap = 1'b1, i_current_multiplier_strap = 1'b1;
    logic i_power_good_qualifier_n = 1'b1, i_power_down_in_n = 1'b1;
    logic i_system_reset_req = 1'b0;
    logic [1:0] src_cnt = 2'h0;
    logic [N_CLK-1:0] i_src_clk, o_clk_out;
    logic i_serial_clock, i_serial_data_pin, host_sda_oe;
    logic o_strap_pins_oe, o_system_reset_out_n, o_system_reset_out_n_oe;
    logic o_power_down, o_cpu_clock_true, o_cpu_clock_true_oe;
    logic o_cpu_clock_comp, o_cpu_clock_comp_oe, o_cpu_push_pull;
    logic o_current_mult_six, o_synth_settled, o_serial_data_pin;
    logic o_serial_data_pin_oe;
    logic [3:0] o_freq_code;
    logic [11:0] o_cpu_tenths_mhz, o_agp_tenths_mhz, o_pci_tenths_mhz;
    int errors = 0, n_tests = 0;
    always #25 i_clk = !i_clk;
    always @(negedge i_clk) src_cnt <= src_cnt + 2'h1;
    assign i_src_clk = {N_CLK{src_cnt[1]}};
    assign i_serial_data_pin = !(host_sda_oe || o_serial_data_pin_oe);
    clock_chip_strap_and_serial_ctrl #(.P_SETTLE_CYCLES(8))
        clock_chip_strap_and_serial_ctrl_inst (.*);
    smb_host smb_host_inst (.i_clk(i_clk), .i_sda(i_serial_data_pin),
        .o_scl(i_serial_clock), .o_sda_oe(host_sda_oe));
    // ****************
    // Helpers
    // ****************
    task automatic check(input string nm, input logic [11:0] seen,
        input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ever_high(input int k, output logic hit);
        hit = 1'b0;
        repeat (40) begin
            @(negedge i_clk);
            hit = hit | o_clk_out[k];
        end
    endtask
    task automatic read_map(input logic [7:0] e[7]);
        logic [7:0] d[$];
        int acks;
        smb_host_inst.bread(8'h00, 8, d, acks);
        check("read acks", 12'(acks), 12'h3);
        check("count", d[0], N_REG_BYTE);
        for (int i = 0; i < 7; i++) begin
            check("map byte", d[i+1], e[i]);
        end
    endtask
    task automatic finish_test();
        $display("Errors %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_power_up();
        repeat (2) @(negedge i_clk);
        check("strap oe", o_strap_pins_oe, 12'h0);
        i_supply_ok = 1'b1;
        repeat (6) @(negedge i_clk);
        check("strap oe", o_strap_pins_oe, 12'h1);
        check("push pull", o_cpu_push_pull, 12'h1);
        check("mult six", o_current_mult_six, 12'h1);
        check("code", o_freq_code, 12'hA);
        check("cpu", o_cpu_tenths_mhz, 12'h685);
        check("agp", o_agp_tenths_mhz, 12'h29C);
        check("pci", o_pci_tenths_mhz, 12'h14E);
        repeat (20) @(negedge i_clk);
        check("settled", o_synth_settled, 12'h1);
        check("held", o_clk_out[11:0], 12'h0);
    endtask
    task automatic t_power_good();
        logic hit;
        i_freq_select_strap = 4'h3;
        i_current_multiplier_strap = 1'b0;
        i_power_good_qualifier_n = 1'b0;
        repeat (10) @(negedge i_clk);
        check("code", o_freq_code, 12'h3);
        check("cpu", o_cpu_tenths_mhz, 12'h535);
        check("mult six", o_current_mult_six, 12'h0);
        ever_high(2, hit);
        check("runs", hit, 12'h1);
        i_power_good_qualifier_n = 1'b1;
        i_freq_select_strap = 4'hF;
        i_current_multiplier_strap = 1'b1;
        repeat (10) @(negedge i_clk);
        i_power_good_qualifier_n = 1'b0;
        repeat (10) @(negedge i_clk);
        check("code kept", o_freq_code, 12'h3);
        check("mult kept", o_current_mult_six, 12'h0);
    endtask
    task automatic t_byte_ops();
        logic [7:0] d[$];
        int acks;
        logic hit;
        smb_host_inst.bwrite(8'hD2, 8'h82, {8'h7E}, acks);
        check("acks", 12'(acks), 12'h3);
        repeat (10) @(negedge i_clk);
        ever_high(2, hit);
        check("stopped low", hit, 12'h0);
        ever_high(3, hit);
        check("neighbour runs", hit, 12'h1);
        smb_host_inst.bread(8'h82, 1, d, acks);
        check("read back", d[0], 12'h7E);
        smb_host_inst.bwrite(8'hD2, 8'h82, {8'h7F}, acks);
        ever_high(2, hit);
        check("restarted", hit, 12'h1);
    endtask
    task automatic t_block_write();
        int acks;
        smb_host_inst.bwrite(8'hD2, 8'h00,
            {8'h03, 8'h08, 8'h7D, 8'h55, 8'h11}, acks);
        check("acks", 12'(acks), 12'h7);
        read_map('{8'h39, 8'h7C, 8'h55, CFG3_RST, CFG4_RST, CFG5_RST,
            CFG6_RST});
    endtask
    task automatic t_refuse();
        logic [7:0] d[$];
        int acks;
        logic a;
        smb_host_inst.bwrite(8'hD4, 8'h82, {8'h00}, acks);
        check("other address", 12'(acks), 12'h0);
        smb_host_inst.bwrite(8'hD2, 8'h05, {8'h00}, acks);
        check("bad block cmd", 12'(acks), 12'h1);
        smb_host_inst.bread(8'h82, 1, d, acks);
        check("untouched", d[0], 12'h55);
        smb_host_inst.bwrite(8'hD2, 8'h87, {8'hFF}, acks);
        smb_host_inst.bread(8'h87, 1, d, acks);
        check("beyond map", d[0], 12'h0);
        smb_host_inst.start();
        smb_host_inst.put(8'hD3, a);
        smb_host_inst.stop();
        check("read no cmd", a, 12'h0);
    endtask
    task automatic t_pin_fn();
        int acks;
        i_power_down_in_n = 1'b0;
        i_system_reset_req = 1'b1;
        repeat (4) @(negedge i_clk);
        check("reset oe", o_system_reset_out_n_oe, 12'h1);
        check("no pd", o_power_down, 12'h0);
        smb_host_inst.bwrite(8'hD2, 8'h86, {8'h80}, acks);
        repeat (10) @(negedge i_clk);
        check("reset oe off", o_system_reset_out_n_oe, 12'h0);
        check("pd", o_power_down, 12'h1);
        check("clocks low", o_clk_out[11:0], 12'h0);
        i_power_down_in_n = 1'b1;
        i_system_reset_req = 1'b0;
        repeat (10) @(negedge i_clk);
        check("pd off", o_power_down, 12'h0);
    endtask
    task automatic t_open_drain();
        logic hit;
        i_rstn = 1'b0;
        i_supply_ok = 1'b0;
        i_cpu_family_strap = 1'b0;
        i_power_good_qualifier_n = 1'b1;
        repeat (4) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (2) @(negedge i_clk);
        i_supply_ok = 1'b1;
        repeat (20) @(negedge i_clk);
        check("push pull", o_cpu_push_pull, 12'h0);
        check("cpu true", o_cpu_clock_true, 12'h0);
        ever_high(CK_CRYSTAL_COPY_OUT_B, hit);
        check("copy b", hit, 12'h1);
        ever_high(CK_CPU, hit);
        check("no pg wait", hit, 12'h1);
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        i_rstn = 1'b1;
        t_power_up();
        t_power_good();
        read_map('{8'h31, 8'h7C, CFG2_RST, CFG3_RST, CFG4_RST, CFG5_RST,
            CFG6_RST});
        t_byte_ops();
        t_block_write();
        t_refuse();
        t_pin_fn();
        t_open_drain();
        finish_test();
    end
    initial begin
        #2000000;
        errors++;
        finish_test();
    end
endmodule
